// >>> logic/adc_bus_pkg.sv
// Shared constants for the analog I/O bus interface block.
// Assumes a single 200 MHz system clock; bus pins arrive asynchronously.
package adc_bus_pkg;
    localparam int  DATA_W         = 8;
    localparam int  CLK_PERIOD_PS  = 5000;
    // Internal conversion time in nanoseconds
    localparam int  CONV_TIME_NS   = 2000;
    // Longest figure rounds down, never below one cycle
    localparam int  CONV_CYCLES_RAW = (CONV_TIME_NS * 1000) / CLK_PERIOD_PS;
    localparam int  CONV_CYCLES    = (CONV_CYCLES_RAW < 1) ? 1 : CONV_CYCLES_RAW;
    localparam int  CNT_W          = 12;
    localparam logic [7:0] DAC_RESET_VALUE  = 8'h00;
    localparam logic [7:0] RESULT_RESET_VAL = 8'h00;
    localparam logic [2:0] SYNC_RESET_ALL1  = 3'h7;

    typedef enum logic [1:0] {
        PH_IDLE    = 2'b00,
        PH_CONVERT = 2'b01,
        PH_DONE    = 2'b11
    } conv_state_t;
endpackage

// >>> logic/adc_read_start_bus_interface.sv
// Device-side bus logic: read-started conversion, busy/interrupt, DAC latches.
// Assumes asynchronous bus strobes from an 8-bit host; analog core outside
// supplies the converted code and takes the hold command.
//
// What this block does
// - Chip select plus read low starts conversion.
// - Busy driven low after conversion starts.
// - Sample held on falling read strobe edge.
// - Busy returns high; host takes new result.
// - Previous result on bus during conversion.
// - Interrupt asserted when conversion completes.
// - DAC register latched on write rising edge.
// - Interrupt cleared by rising select or read.
// - Reset zeroes DACs; no transparent latch.
`timescale 1ns/100ps
module adc_read_start_bus_interface #(
    parameter int CONV_CYCLES = adc_bus_pkg::CONV_CYCLES
) (
    input  wire logic       i_clk_sys,
    input  wire logic       i_rst,
    input  wire logic       i_cs_n,
    input  wire logic       i_rd_n,
    input  wire logic       i_wr_n,
    input  wire logic       i_dac_sel_b,
    input  wire logic       i_start_convert_n,
    input  wire logic       i_reset_n,
    input  wire logic [7:0] i_data,
    input  wire logic [7:0] i_adc_code,
    output logic      [7:0] o_data,
    output logic            o_data_oe,
    output logic            o_busy_n,
    output logic            o_int_n,
    output logic            o_hold,
    output logic      [7:0] o_dac_a,
    output logic      [7:0] o_dac_b
);
    // ==========================================================
    // Pin synchronisers
    // ==========================================================
    logic [2:0] cs_sync_reg,  cs_sync_next;
    logic [2:0] rd_sync_reg,  rd_sync_next;
    logic [2:0] wr_sync_reg,  wr_sync_next;
    logic [2:0] rst_sync_reg, rst_sync_next;
    logic       cs_q_reg,  cs_q_next;
    logic       rd_q_reg,  rd_q_next;
    logic       wr_q_reg,  wr_q_next;
    logic       sel_q_reg, sel_q_next;
    logic [7:0] din_q_reg, din_q_next;

    // A level counts only once stages two and three agree
    function automatic logic settle(input logic [2:0] s, input logic prev);
        settle = (s[1] == s[2]) ? s[2] : prev;
    endfunction

    always_comb begin
        cs_sync_next  = {cs_sync_reg[1:0], i_cs_n};
        rd_sync_next  = {rd_sync_reg[1:0], i_rd_n};
        wr_sync_next  = {wr_sync_reg[1:0], i_wr_n};
        rst_sync_next = {rst_sync_reg[1:0], i_reset_n};
        cs_q_next     = settle(cs_sync_reg, cs_q_reg);
        rd_q_next     = settle(rd_sync_reg, rd_q_reg);
        wr_q_next     = settle(wr_sync_reg, wr_q_reg);
        // Select and data are stable around the write strobe edge
        sel_q_next    = i_dac_sel_b;
        din_q_next    = i_data;
    end

    always_ff @(posedge i_clk_sys or posedge i_rst) begin
        if (i_rst) begin
            cs_sync_reg  <= adc_bus_pkg::SYNC_RESET_ALL1;
            rd_sync_reg  <= adc_bus_pkg::SYNC_RESET_ALL1;
            wr_sync_reg  <= adc_bus_pkg::SYNC_RESET_ALL1;
            rst_sync_reg <= adc_bus_pkg::SYNC_RESET_ALL1;
            cs_q_reg     <= 1'b1;
            rd_q_reg     <= 1'b1;
            wr_q_reg     <= 1'b1;
            sel_q_reg    <= 1'b0;
            din_q_reg    <= 8'h00;
        end else begin
            cs_sync_reg  <= cs_sync_next;
            rd_sync_reg  <= rd_sync_next;
            wr_sync_reg  <= wr_sync_next;
            rst_sync_reg <= rst_sync_next;
            cs_q_reg     <= cs_q_next;
            rd_q_reg     <= rd_q_next;
            wr_q_reg     <= wr_q_next;
            sel_q_reg    <= sel_q_next;
            din_q_reg    <= din_q_next;
        end
    end

    logic rd_acc;
    logic rd_fall;
    logic rd_end;
    logic wr_rise;
    logic dac_clr;
    logic rd_acc_q_reg;
    logic wr_acc_q_reg;

    assign rd_acc  = ~cs_q_reg & ~rd_q_reg;
    assign rd_fall = rd_acc & ~rd_acc_q_reg;
    assign rd_end  = ~rd_acc & rd_acc_q_reg;
    assign wr_rise = wr_q_reg & wr_acc_q_reg;
    assign dac_clr = (rst_sync_reg[1] == rst_sync_reg[2]) & ~rst_sync_reg[2];

    always_ff @(posedge i_clk_sys or posedge i_rst) begin
        if (i_rst) begin
            rd_acc_q_reg <= 1'b0;
            wr_acc_q_reg <= 1'b0;
        end else begin
            rd_acc_q_reg <= rd_acc;
            wr_acc_q_reg <= ~cs_q_reg & ~wr_q_reg;
        end
    end

    // ==========================================================
    // Conversion control
    // ==========================================================
    adc_bus_pkg::conv_state_t state_reg, state_next;
    logic [adc_bus_pkg::CNT_W-1:0] cnt_reg, cnt_next;
    logic [7:0] result_reg, result_next;
    logic       int_pend_reg, int_pend_next;
    logic       done_evt;

    always_comb begin
        state_next    = state_reg;
        cnt_next      = cnt_reg;
        result_next   = result_reg;
        int_pend_next = int_pend_reg;
        done_evt      = 1'b0;
        // Clear first so a completion in the same cycle wins
        if (rd_end) begin
            int_pend_next = 1'b0;
        end
        unique case (state_reg)
            adc_bus_pkg::PH_IDLE: begin
                // Start pin tied high by system; a low level blocks starts
                if (rd_fall && i_start_convert_n) begin
                    state_next = adc_bus_pkg::PH_CONVERT;
                    cnt_next   = CONV_CYCLES[adc_bus_pkg::CNT_W-1:0];
                end
            end
            adc_bus_pkg::PH_CONVERT: begin
                if (cnt_reg <= 12'h001) begin
                    state_next    = adc_bus_pkg::PH_DONE;
                    result_next   = i_adc_code;
                    int_pend_next = 1'b1;
                    done_evt      = 1'b1;
                end else begin
                    cnt_next = cnt_reg - 12'h001;
                end
            end
            adc_bus_pkg::PH_DONE: begin
                // Wait for the stalled read to end before rearming
                if (!rd_acc) begin
                    state_next = adc_bus_pkg::PH_IDLE;
                end
            end
            default: begin
                state_next = adc_bus_pkg::PH_IDLE;
            end
        endcase
    end

    always_ff @(posedge i_clk_sys or posedge i_rst) begin
        if (i_rst) begin
            state_reg    <= adc_bus_pkg::PH_IDLE;
            cnt_reg      <= '0;
            result_reg   <= adc_bus_pkg::RESULT_RESET_VAL;
            int_pend_reg <= 1'b0;
        end else begin
            state_reg    <= state_next;
            cnt_reg      <= cnt_next;
            result_reg   <= result_next;
            int_pend_reg <= int_pend_next;
        end
    end

    assign o_busy_n  = (state_reg != adc_bus_pkg::PH_CONVERT);
    assign o_hold    = (state_reg == adc_bus_pkg::PH_CONVERT);
    assign o_int_n   = ~int_pend_reg;
    assign o_data_oe = rd_acc;
    // Old result stays on the bus until the new one is stored
    assign o_data    = result_reg;

    // ==========================================================
    // DAC registers
    // ==========================================================
    logic [7:0] dac_a_reg, dac_a_next;
    logic [7:0] dac_b_reg, dac_b_next;

    always_comb begin
        dac_a_next = dac_a_reg;
        dac_b_next = dac_b_reg;
        if (dac_clr) begin
            dac_a_next = adc_bus_pkg::DAC_RESET_VALUE;
            dac_b_next = adc_bus_pkg::DAC_RESET_VALUE;
        end else if (wr_rise) begin
            // Edge only: a held-low strobe never passes data through
            if (sel_q_reg) begin
                dac_b_next = din_q_reg;
            end else begin
                dac_a_next = din_q_reg;
            end
        end
    end

    always_ff @(posedge i_clk_sys or posedge i_rst) begin
        if (i_rst) begin
            dac_a_reg <= adc_bus_pkg::DAC_RESET_VALUE;
            dac_b_reg <= adc_bus_pkg::DAC_RESET_VALUE;
        end else begin
            dac_a_reg <= dac_a_next;
            dac_b_reg <= dac_b_next;
        end
    end

    assign o_dac_a = dac_a_reg;
    assign o_dac_b = dac_b_reg;

    // ==========================================================
    // Assertions
    // ==========================================================
    property p_start_busy;
        @(posedge i_clk_sys) disable iff (i_rst)
        (state_reg == adc_bus_pkg::PH_IDLE && rd_fall && i_start_convert_n) |=> !o_busy_n;
    endproperty
    a_start_busy: assert property (p_start_busy) else $error("busy not low after start");

    property p_no_start_low;
        @(posedge i_clk_sys) disable iff (i_rst)
        (state_reg == adc_bus_pkg::PH_IDLE && !i_start_convert_n) |=> o_busy_n;
    endproperty
    a_no_start_low: assert property (p_no_start_low) else $error("start with pin low");

    property p_start_cause;
        @(posedge i_clk_sys) disable iff (i_rst)
        $fell(o_busy_n) |-> $past(rd_fall);
    endproperty
    a_start_cause: assert property (p_start_cause) else $error("busy fell without read");

    property p_hold_busy;
        @(posedge i_clk_sys) disable iff (i_rst)
        o_hold == !o_busy_n;
    endproperty
    a_hold_busy: assert property (p_hold_busy) else $error("hold not tied to busy");

    property p_busy_len;
        @(posedge i_clk_sys) disable iff (i_rst)
        $fell(o_busy_n) |-> (!o_busy_n [*8]);
    endproperty
    a_busy_len: assert property (p_busy_len) else $error("busy too short");

    property p_busy_int;
        @(posedge i_clk_sys) disable iff (i_rst)
        $rose(o_busy_n) |-> $fell(o_int_n) && o_data == $past(i_adc_code);
    endproperty
    a_busy_int: assert property (p_busy_int) else $error("end without int or data");

    property p_old_data;
        @(posedge i_clk_sys) disable iff (i_rst)
        (!o_busy_n && $past(!o_busy_n)) |-> $stable(o_data);
    endproperty
    a_old_data: assert property (p_old_data) else $error("data changed mid conversion");

    property p_int_clear;
        @(posedge i_clk_sys) disable iff (i_rst)
        (rd_end && !(state_reg == adc_bus_pkg::PH_CONVERT && cnt_reg <= 12'h001)) |=> o_int_n;
    endproperty
    a_int_clear: assert property (p_int_clear) else $error("int not cleared");

    property p_int_source;
        @(posedge i_clk_sys) disable iff (i_rst)
        $fell(o_int_n) |-> $past(state_reg == adc_bus_pkg::PH_CONVERT);
    endproperty
    a_int_source: assert property (p_int_source) else $error("int without conversion");

    property p_dac_write;
        @(posedge i_clk_sys) disable iff (i_rst)
        (wr_rise && !dac_clr && !sel_q_reg) |=> o_dac_a == $past(din_q_reg);
    endproperty
    a_dac_write: assert property (p_dac_write) else $error("DAC A not latched");

    property p_dac_clr;
        @(posedge i_clk_sys) disable iff (i_rst)
        dac_clr |=> (o_dac_a == 8'h00 && o_dac_b == 8'h00);
    endproperty
    a_dac_clr: assert property (p_dac_clr) else $error("DAC not cleared");

    c_conv: cover property (@(posedge i_clk_sys) disable iff (i_rst) $rose(o_busy_n));
    c_wr_b: cover property (@(posedge i_clk_sys) disable iff (i_rst) wr_rise && sel_q_reg);
    c_int_clr: cover property (@(posedge i_clk_sys) disable iff (i_rst) $rose(o_int_n));
endmodule // adc_read_start_bus_interface

// >>> dv/host_bus_model.sv
// Host bus partner: an 8-bit processor whose wait input follows busy.
// Assumes one clock shared with the device; drives strobes after rising edges.
`timescale 1ns/100ps
module host_bus_model (
    input  wire logic       i_clk_sys,
    input  wire logic       i_busy_n,
    input  wire logic       i_hold,
    input  wire logic       i_data_oe,
    input  wire logic [7:0] i_data,
    output logic            o_cs_n,
    output logic            o_rd_n,
    output logic            o_wr_n,
    output logic            o_sel_b,
    output logic      [7:0] o_data
);
    logic [7:0] old_data;
    logic [7:0] new_data;
    logic       hold_seen;
    int         busy_len;
    int         wait_len;

    initial begin
        o_cs_n  = 1'b1;
        o_rd_n  = 1'b1;
        o_wr_n  = 1'b1;
        o_sel_b = 1'b0;
        o_data  = 8'h00;
    end

    // ==========================================================
    // Read that starts a conversion and waits it out
    task automatic read_cycle();
        busy_len  = 0;
        wait_len  = 0;
        hold_seen = 1'b1;
        @(posedge i_clk_sys);
        o_cs_n <= 1'b0;
        o_rd_n <= 1'b0;
        do begin
            @(posedge i_clk_sys);
            wait_len++;
        end while (i_busy_n !== 1'b0 && wait_len < 20);
        old_data = i_data_oe ? i_data : ~i_data;
        // Stays stalled as long as busy is low, bounded well past 2 us
        while (i_busy_n === 1'b0 && busy_len < 1000) begin
            busy_len++;
            hold_seen &= i_hold;
            @(posedge i_clk_sys);
        end
        new_data = i_data_oe ? i_data : ~i_data;
        o_cs_n <= 1'b1;
        o_rd_n <= 1'b1;
    endtask

    // ==========================================================
    // Write with no wait states; data flips once released
    task automatic write_cycle(input logic sel, input logic [7:0] d);
        @(posedge i_clk_sys);
        o_cs_n  <= 1'b0;
        o_wr_n  <= 1'b0;
        o_sel_b <= sel;
        o_data  <= d;
        repeat (6) @(posedge i_clk_sys);
        o_wr_n <= 1'b1;
        repeat (6) @(posedge i_clk_sys);
        o_cs_n <= 1'b1;
        o_data <= ~d;
    endtask
endmodule // host_bus_model

// >>> dv/adc_read_start_bus_interface_tb.sv
// Self-checking bench for the read-started conversion bus logic.
// Assumes the host model above; conversion shortened through CONV_CYCLES.
`timescale 1ns/100ps
module adc_read_start_bus_interface_tb;
    localparam int CONV = 10;
    logic       i_clk_sys;
    logic       i_rst;
    logic       i_reset_n;
    logic [7:0] i_adc_code;
    wire        cs_n;
    wire        rd_n;
    wire        wr_n;
    wire        sel_b;
    wire  [7:0] wdata;
    logic [7:0] o_data;
    logic [7:0] o_dac_a;
    logic [7:0] o_dac_b;
    logic       o_data_oe;
    logic       o_busy_n;
    logic       o_int_n;
    logic       o_hold;
    int         n_fail = 0;
    int         samples_checked = 0;

    adc_read_start_bus_interface #(.CONV_CYCLES(CONV)) uut (
        .i_clk_sys(i_clk_sys), .i_rst(i_rst), .i_cs_n(cs_n), .i_rd_n(rd_n), .i_wr_n(wr_n),
        .i_dac_sel_b(sel_b), .i_start_convert_n(1'b1), .i_reset_n(i_reset_n),
        .i_data(wdata), .i_adc_code(i_adc_code), .o_data(o_data), .o_data_oe(o_data_oe),
        .o_busy_n(o_busy_n), .o_int_n(o_int_n), .o_hold(o_hold), .o_dac_a(o_dac_a), .o_dac_b(o_dac_b));

    host_bus_model host (
        .i_clk_sys(i_clk_sys), .i_busy_n(o_busy_n), .i_hold(o_hold), .i_data_oe(o_data_oe),
        .i_data(o_data), .o_cs_n(cs_n), .o_rd_n(rd_n), .o_wr_n(wr_n), .o_sel_b(sel_b), .o_data(wdata));

    // ==========================================================
    // Shared helpers
    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        samples_checked++;
        if (got !== exp) begin
            n_fail++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic test_done();
        if (n_fail == 0 && samples_checked > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    // ==========================================================
    // Scenarios
    task automatic t_reset();
        check({o_busy_n, o_int_n, o_hold, o_data_oe}, 8'h0c);
        check(o_data, 8'h00);
        check(o_dac_a | o_dac_b, 8'h00);
    endtask

    task automatic t_read(input logic [7:0] code, input logic [7:0] prev);
        int k;
        // Realign to a rising edge after the previous scenario's settle delay
        @(posedge i_clk_sys);
        i_adc_code <= code;
        host.read_cycle();
        check(8'(host.wait_len < 20), 8'h01);
        check(host.old_data, prev);
        check(8'(host.busy_len), 8'(CONV));
        check({7'h00, host.hold_seen}, 8'h01);
        check(host.new_data, code);
        #1 check({7'h00, o_int_n}, 8'h00);
        k = 0;
        while (o_int_n !== 1'b1 && k < 12) begin
            @(posedge i_clk_sys);
            k++;
        end
        #1 check({o_int_n, o_busy_n}, 8'h03);
    endtask

    task automatic t_write();
        fork
            host.write_cycle(1'b0, 8'h3c);
            begin
                repeat (6) @(posedge i_clk_sys);
                check(o_dac_a, 8'h00);
            end
        join
        check(o_dac_a, 8'h3c);
        host.write_cycle(1'b1, 8'hc3);
        check(o_dac_b, 8'hc3);
        check(o_dac_a, 8'h3c);
        i_reset_n <= 1'b0;
        repeat (8) @(posedge i_clk_sys);
        check(o_dac_a | o_dac_b, 8'h00);
        i_reset_n <= 1'b1;
    endtask

    // ==========================================================
    // Clock, watchdog and main sequence
    initial begin
        i_clk_sys = 1'b0;
        forever #2.5 i_clk_sys = ~i_clk_sys;
    end

    initial begin
        #20000;
        n_fail++;
        test_done();
    end

    initial begin
        i_rst      = 1'b1;
        i_reset_n  = 1'b1;
        i_adc_code = 8'h00;
        repeat (3) @(posedge i_clk_sys);
        i_rst <= 1'b0;
        repeat (2) @(posedge i_clk_sys);
        t_reset();
        t_read(8'h5a, 8'h00);
        t_read(8'ha5, 8'h5a);
        t_read(8'hff, 8'ha5);
        t_write();
        test_done();
    end
endmodule // adc_read_start_bus_interface_tb
